// ==== src/plsc_pkg.sv ====
// Register map, field positions and timing of the regulator/system bank
// Functional notes
// [RL1] Regulator voltage field is six bits read/write; bits 7:6 read zero.
// [RL2] Control bit 7 enables the regulator; keep-alive register holds only it.
// [RL3] Control bit 2 requests output discharge while the regulator is off.
// [RL4] Control bit 1 lets regulator faults raise an interrupt.
// [RL5] Control bit 0 reads live power-good, read-only.
// [RL6] Button control bit 7 enables interrupt on button press.
// [RL7] Button control bit 6 enables interrupt on button release.
// [RL8] Button control bit 1: watchdog expiry starts a soft reset; with bit 0 also set the code starts only a power cycle.
// [RL9] Button control bit 0: watchdog expiry starts a power cycle.
// [RL10] Entering sleep clears both watchdog enable bits.
// [RL11] Interrupt address is read-only, names the source block, resets 0xff.
// [RL12] Reading interrupt address returns it, then restores it to 0xff.
// [RL13] Button status bit 7 shows a triggered press interrupt.
// [RL14] Button status bit 6 shows a triggered release interrupt.
// [RL15] Button status bit 5 shows the live button level.
// [RL16] Arm with bit 3, then bit 4 turns every output off.
// [RL17] System control bit 0 starts a power cycle after a fixed delay.
// [RL18] Reset flag bit 1 sets after power cycle, clears on read.
// [RL19] Reset flag bit 0 sets after soft reset, clears on read.
// [RL20] Active-low interrupt holds while any enabled event stays pending.
package plsc_pkg;

	localparam int         ADDR_W         = 12;
	localparam int         DATA_W         = 32;
	localparam int         VSEL_W         = 6;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_LDO11_VSEL = 8'h90;
	localparam logic [7:0] IDX_LDO11_CTRL = 8'h91;
	localparam logic [7:0] IDX_LDO12_VSEL = 8'ha0;
	localparam logic [7:0] IDX_LDO12_CTRL = 8'ha1;
	localparam logic [7:0] IDX_KEEP_CTRL  = 8'hb1;
	localparam logic [7:0] IDX_BTN_CTRL   = 8'hc0;
	localparam logic [7:0] IDX_INT_ADDR   = 8'hc1;
	localparam logic [7:0] IDX_BTN_STAT   = 8'hc2;
	localparam logic [7:0] IDX_SYS_CTRL   = 8'hc3;
	localparam logic [7:0] IDX_RST_FLAGS  = 8'hc5;

	localparam logic [7:0] CTL_IDX [3]    = '{8'h91, 8'ha1, 8'hb1};
	localparam logic [7:0] VSEL_IDX [2]   = '{8'h90, 8'ha0};

	// Field positions
	localparam int         B_EN           = 7;
	localparam int         B_DIS          = 2;
	localparam int         B_FIE          = 1;
	localparam int         B_PRESS        = 7;
	localparam int         B_REL          = 6;
	localparam int         B_WDSR         = 1;
	localparam int         B_WDPC         = 0;
	localparam int         B_OFF          = 4;
	localparam int         B_ARM          = 3;
	localparam int         B_SOFTWARE_POWER_CYCLE         = 0;
	localparam int         B_PCF          = 1;
	localparam int         B_SRF          = 0;

	// Reset values
	localparam logic [5:0] VSEL_RST       = 6'h00;
	localparam logic [7:0] INT_ADDR_RST   = 8'hff;

	// Timing
	localparam int         CLK_KHZ        = 10000;
	localparam int         SOFTWARE_POWER_CYCLE_DELAY_MS  = 8;
	localparam int         SOFTWARE_POWER_CYCLE_DELAY_CYC = SOFTWARE_POWER_CYCLE_DELAY_MS * CLK_KHZ;

endpackage

// ==== src/plsc_regs.sv ====
// APB register bank for the regulator and system-control group
`timescale 1ns/1ps
module plsc_regs
	import plsc_pkg::*;
#(
	parameter int SOFTWARE_POWER_CYCLE_DELAY = SOFTWARE_POWER_CYCLE_DELAY_CYC
) (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output wire logic [DATA_W-1:0] prdata,
	output wire logic              pready,
	output wire logic              pslverr,
	input  wire logic [1:0]        powerGood,
	input  wire logic [1:0]        ldoFault,
	input  wire logic              pushButtonInN,
	input  wire logic              watchdogExpire,
	input  wire logic              sleepEnter,
	input  wire logic              powerCycleDone,
	input  wire logic              softResetDone,
	output wire logic [2:0]        ldoEnable,
	output wire logic [VSEL_W-1:0] ldo11VoltageSelect,
	output wire logic [VSEL_W-1:0] ldo12VoltageSelect,
	output wire logic [1:0]        outputDischargeEnable,
	output wire logic              globalOff,
	output wire logic              powerCycleStart,
	output wire logic              softResetStart,
	output wire logic              irqN
);

	localparam int CNT_W = $clog2(SOFTWARE_POWER_CYCLE_DELAY + 1);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		isMapped = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
			(i == IDX_LDO11_VSEL || i == IDX_LDO11_CTRL ||
			 i == IDX_LDO12_VSEL || i == IDX_LDO12_CTRL ||
			 i == IDX_KEEP_CTRL  || i == IDX_BTN_CTRL   ||
			 i == IDX_INT_ADDR   || i == IDX_BTN_STAT   ||
			 i == IDX_SYS_CTRL   || i == IDX_RST_FLAGS);
	endfunction

	logic [DATA_W-1:0] prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;
	logic              vsel_ff [2];
	logic [5:0]        vselReg_ff [2];
	logic              en_ff [3];
	logic              enOut_ff [3];
	logic              dis_ff [2];
	logic              disOut_ff [2];
	logic              fie_ff [2];
	logic              faultPend_ff [2];
	logic              faultPrev_ff [2];
	logic              fSet [2];
	logic              pressIe_ff;
	logic              relIe_ff;
	logic              wdSr_ff;
	logic              wdPc_ff;
	logic              btnLevel_ff;
	logic              pressSt_ff;
	logic              relSt_ff;
	logic [7:0]        intAddr_ff;
	logic              arm_ff;
	logic              off_ff;
	logic              software_power_cycle_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic              pcStart_ff;
	logic              srStart_ff;
	logic              pcf_ff;
	logic              srf_ff;
	logic              irqN_ff;
	logic [7:0]        rdByte;
	logic [7:0]        evAddr;

	wire logic [7:0] idx    = paddr[9:2];
	wire logic       mapped = isMapped(paddr);
	wire logic       setup  = psel & ~penable;
	wire logic       acc    = psel & penable & pready_ff;
	wire logic       wrEn   = acc & pwrite & mapped;
	wire logic       rdDone = acc & ~pwrite & mapped;
	wire logic [7:0] wb     = pwdata[7:0];
	wire logic [7:0] snap   = prdata_ff[7:0];

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rdByte = 8'h00;
		case (idx)
			IDX_LDO11_VSEL: rdByte = {2'h0, vselReg_ff[0]}; // RL1
			IDX_LDO12_VSEL: rdByte = {2'h0, vselReg_ff[1]}; // RL1
			IDX_LDO11_CTRL: rdByte = {en_ff[0], 4'h0, dis_ff[0],
				fie_ff[0], powerGood[0]}; // RL5
			IDX_LDO12_CTRL: rdByte = {en_ff[1], 4'h0, dis_ff[1],
				fie_ff[1], powerGood[1]}; // RL5
			IDX_KEEP_CTRL:  rdByte = {en_ff[2], 7'h00}; // RL2
			IDX_BTN_CTRL:   rdByte = {pressIe_ff, relIe_ff, 4'h0,
				wdSr_ff, wdPc_ff};
			IDX_INT_ADDR:   rdByte = intAddr_ff; // RL11
			IDX_BTN_STAT:   rdByte = {pressSt_ff, relSt_ff,
				btnLevel_ff, 5'h00}; // RL13 RL14 RL15
			IDX_SYS_CTRL:   rdByte = {3'h0, off_ff, arm_ff, 2'h0,
				software_power_cycle_ff};
			IDX_RST_FLAGS:  rdByte = {6'h00, pcf_ff, srf_ff};
			default:        rdByte = 8'h00;
		endcase
	end

	// Answer one cycle after setup; data latched early and held
	always_ff @(posedge clk) begin
		if (reset) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else if (ce) begin
			pready_ff <= setup;
			if (setup) begin
				pslverr_ff <= ~mapped;
				prdata_ff  <= (mapped & ~pwrite) ?
					{24'h000000, rdByte} : '0;
			end
		end
	end

	// ------------------------------------------------------------
	// Regulator channels
	// ------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_en
		wire logic hit = wrEn & (idx == CTL_IDX[i]);
		always_ff @(posedge clk) begin
			if (reset) begin
				en_ff[i]    <= 1'b0;
				enOut_ff[i] <= 1'b0;
			end else if (ce) begin
				if (hit)
					en_ff[i] <= wb[B_EN]; // RL2
				enOut_ff[i] <= en_ff[i] & ~off_ff; // RL16
			end
		end
		assign ldoEnable[i] = enOut_ff[i];
	end

	for (genvar i = 0; i < 2; i++) begin : g_ldo
		wire logic vHit  = wrEn & (idx == VSEL_IDX[i]);
		wire logic cHit  = wrEn & (idx == CTL_IDX[i]);
		wire logic cRead = rdDone & (idx == CTL_IDX[i]);
		// Edge, not level, so a stuck fault is raised once
		assign fSet[i] = ldoFault[i] & ~faultPrev_ff[i] & fie_ff[i]; // RL4
		always_ff @(posedge clk) begin
			if (reset) begin
				vselReg_ff[i]   <= VSEL_RST;
				dis_ff[i]       <= 1'b0;
				fie_ff[i]       <= 1'b0;
				disOut_ff[i]    <= 1'b0;
				faultPend_ff[i] <= 1'b0;
				faultPrev_ff[i] <= 1'b0;
			end else if (ce) begin
				if (vHit)
					vselReg_ff[i] <= wb[VSEL_W-1:0]; // RL1
				if (cHit) begin
					dis_ff[i] <= wb[B_DIS]; // RL3
					fie_ff[i] <= wb[B_FIE]; // RL4
				end
				disOut_ff[i] <= dis_ff[i] &
					~(en_ff[i] & ~off_ff); // RL3
				faultPrev_ff[i] <= ldoFault[i];
				if (fSet[i])
					faultPend_ff[i] <= 1'b1; // RL20
				else if (cRead)
					faultPend_ff[i] <= 1'b0;
			end
		end
		assign outputDischargeEnable[i] = disOut_ff[i];
	end

	assign ldo11VoltageSelect = vselReg_ff[0];
	assign ldo12VoltageSelect = vselReg_ff[1];

	// ------------------------------------------------------------
	// Push button and watchdog
	// ------------------------------------------------------------
	wire logic pressEvt = ~pushButtonInN & ~btnLevel_ff;
	wire logic relEvt   = pushButtonInN & btnLevel_ff;
	wire logic pSet     = pressEvt & pressIe_ff; // RL6
	wire logic rSet     = relEvt & relIe_ff; // RL7
	wire logic stRead   = rdDone & (idx == IDX_BTN_STAT);
	wire logic bcHit    = wrEn & (idx == IDX_BTN_CTRL);

	always_ff @(posedge clk) begin
		if (reset) begin
			btnLevel_ff <= 1'b0;
			pressSt_ff  <= 1'b0;
			relSt_ff    <= 1'b0;
		end else if (ce) begin
			btnLevel_ff <= ~pushButtonInN; // RL15
			// Only bits seen by the read are cleared; set wins
			if (pSet)
				pressSt_ff <= 1'b1; // RL13
			else if (stRead & snap[B_PRESS])
				pressSt_ff <= 1'b0;
			if (rSet)
				relSt_ff <= 1'b1; // RL14
			else if (stRead & snap[B_REL])
				relSt_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pressIe_ff <= 1'b0;
			relIe_ff   <= 1'b0;
			wdSr_ff    <= 1'b0;
			wdPc_ff    <= 1'b0;
		end else if (ce) begin
			if (bcHit) begin
				pressIe_ff <= wb[B_PRESS]; // RL6
				relIe_ff   <= wb[B_REL]; // RL7
			end
			// Sleep beats a software write in the same cycle
			if (sleepEnter) begin
				wdSr_ff <= 1'b0; // RL10
				wdPc_ff <= 1'b0; // RL10
			end else if (bcHit) begin
				wdSr_ff <= wb[B_WDSR]; // RL8
				wdPc_ff <= wb[B_WDPC]; // RL9
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt source address
	// ------------------------------------------------------------
	always_comb begin
		evAddr = INT_ADDR_RST;
		if (fSet[1])
			evAddr = IDX_LDO12_VSEL;
		if (fSet[0])
			evAddr = IDX_LDO11_VSEL;
		if (pSet | rSet)
			evAddr = IDX_BTN_CTRL;
	end

	wire logic evAny = pSet | rSet | fSet[0] | fSet[1];
	// Restore only if nothing new landed since the data was latched
	wire logic intRd = rdDone & (idx == IDX_INT_ADDR) &
		(intAddr_ff == snap);
	wire logic intFree = (intAddr_ff == INT_ADDR_RST) | intRd;

	always_ff @(posedge clk) begin
		if (reset)
			intAddr_ff <= INT_ADDR_RST; // RL11
		else if (ce) begin
			if (evAny & intFree)
				intAddr_ff <= evAddr; // RL11
			else if (intRd)
				intAddr_ff <= INT_ADDR_RST; // RL12
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			irqN_ff <= 1'b1;
		else if (ce)
			irqN_ff <= ~(pressSt_ff | relSt_ff | faultPend_ff[0] |
				faultPend_ff[1]); // RL20
	end

	// ------------------------------------------------------------
	// Global off, software power cycle, reset flags
	// ------------------------------------------------------------
	wire logic sysHit   = wrEn & (idx == IDX_SYS_CTRL);
	wire logic sipcDone = software_power_cycle_ff &
		(cnt_ff == CNT_W'(SOFTWARE_POWER_CYCLE_DELAY - 1));
	wire logic flRead   = rdDone & (idx == IDX_RST_FLAGS);

	always_ff @(posedge clk) begin
		if (reset) begin
			arm_ff <= 1'b0;
			off_ff <= 1'b0;
		end else if (ce) begin
			if (sysHit) begin
				arm_ff <= wb[B_ARM]; // RL16
				// Off only takes when armed by an earlier write
				if (wb[B_OFF] & arm_ff)
					off_ff <= 1'b1; // RL16
				else if (~wb[B_OFF])
					off_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			software_power_cycle_ff <= 1'b0;
			cnt_ff  <= '0;
		end else if (ce) begin
			if (sysHit) begin
				software_power_cycle_ff <= wb[B_SOFTWARE_POWER_CYCLE]; // RL17
				cnt_ff  <= '0;
			end else if (sipcDone) begin
				software_power_cycle_ff <= 1'b0;
				cnt_ff  <= '0;
			end else if (software_power_cycle_ff)
				cnt_ff <= cnt_ff + 1'b1; // RL17
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pcStart_ff <= 1'b0;
			srStart_ff <= 1'b0;
		end else if (ce) begin
			pcStart_ff <= sipcDone |
				(watchdogExpire & wdPc_ff); // RL9 RL17
			// Power cycle outranks soft reset when both are enabled
			srStart_ff <= watchdogExpire & wdSr_ff &
				~wdPc_ff; // RL8
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pcf_ff <= 1'b0;
			srf_ff <= 1'b0;
		end else if (ce) begin
			if (powerCycleDone)
				pcf_ff <= 1'b1; // RL18
			else if (flRead & snap[B_PCF])
				pcf_ff <= 1'b0; // RL18
			if (softResetDone)
				srf_ff <= 1'b1; // RL19
			else if (flRead & snap[B_SRF])
				srf_ff <= 1'b0; // RL19
		end
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign globalOff       = off_ff;
	assign powerCycleStart = pcStart_ff;
	assign softResetStart  = srStart_ff;
	assign irqN            = irqN_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !ce);

	sequence s_vselWr;
		wrEn && idx == IDX_LDO11_VSEL;
	endsequence
	sequence s_armed;
		sysHit && wb[B_OFF] && arm_ff;
	endsequence
	sequence s_press;
		pressEvt && pressIe_ff;
	endsequence

	a_vsel_store: assert property (s_vselWr |=> ##1 // RL1
		ldo11VoltageSelect == $past(wb[5:0], 2))
		else $error("voltage select not stored");
	a_enable_bit: assert property (wrEn && idx == IDX_KEEP_CTRL // RL2
		&& wb[B_EN] && !off_ff |=> ##1 ldoEnable[2])
		else $error("keep-alive enable not applied");
	a_discharge_off: assert property ( // RL3
		outputDischargeEnable[0] |-> !ldoEnable[0])
		else $error("discharge while regulator on");
	a_fault_gated: assert property (!fie_ff[0] && // RL4
		!faultPend_ff[0] |=> !faultPend_ff[0])
		else $error("masked fault went pending");
	a_pgood_read: assert property (setup && mapped && !pwrite && // RL5
		idx == IDX_LDO11_CTRL |=> prdata[0] == $past(powerGood[0]))
		else $error("power-good read wrong");
	a_press_status: assert property (s_press |=> pressSt_ff // RL6
		##1 !irqN) else $error("press event lost");
	a_sleep_clear: assert property (sleepEnter |=> // RL10
		!wdSr_ff && !wdPc_ff)
		else $error("sleep left watchdog enabled");
	a_wd_cycle: assert property (watchdogExpire && wdPc_ff // RL9
		|=> powerCycleStart && !softResetStart)
		else $error("watchdog power cycle missing");
	a_intaddr_rest: assert property (intRd && !evAny |=> // RL12
		intAddr_ff == INT_ADDR_RST)
		else $error("interrupt address not restored");
	a_global_off: assert property (s_armed |=> globalOff // RL16
		##1 ldoEnable == 3'h0)
		else $error("global off not applied");

endmodule

// ==== verif/plsc_board_model.sv ====
// Board-side model: regulator power-good settling and fault events
`timescale 1ns/1ps
module plsc_board_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] ldoOn,
	input  wire logic [1:0] faultReq,
	output logic      [1:0] powerGood,
	output logic      [1:0] ldoFault
);
	// ------------------------------------------------------------
	// Settling
	// ------------------------------------------------------------
	logic [1:0] settle;

	// Output takes two cycles to cross the good threshold, so a
	// read right after enabling sees the honest lag
	always_ff @(posedge clk) begin
		if (reset) begin
			settle    <= 2'b00;
			powerGood <= 2'b00;
			ldoFault  <= 2'b00;
		end else begin
			settle    <= ldoOn;
			powerGood <= settle & ldoOn;
			ldoFault  <= faultReq;
		end
	end
endmodule

// ==== verif/tb_pmu_ldo_and_system_control_regs.sv ====
// Self-checking bench for the regulator and system-control registers
`timescale 1ns/1ps
module tb_pmu_ldo_and_system_control_regs
	import plsc_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int SD = 20;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic              ce = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic [1:0]        powerGood;
	logic [1:0]        ldoFault;
	logic              pushButtonInN = 1'b1;
	logic [5:0]        evt = '0;
	logic [2:0]        ldoEnable;
	logic [5:0]        v11;
	logic [5:0]        v12;
	logic [1:0]        dis;
	logic              globalOff;
	logic              pcStart;
	logic              srStart;
	logic              irqN;
	logic [31:0]       rd;
	logic              err;
	int                n_fail = 0;
	int                tests_run = 0;
	int                cyc = 0;
	int                n;

	always #50 clk = ~clk;

	plsc_regs #(.SOFTWARE_POWER_CYCLE_DELAY(SD)) u_dut (
		.clk(clk), .reset(reset), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .powerGood(powerGood),
		.ldoFault(ldoFault), .pushButtonInN(pushButtonInN),
		.watchdogExpire(evt[0]), .sleepEnter(evt[1]),
		.powerCycleDone(evt[2]), .softResetDone(evt[3]),
		.ldoEnable(ldoEnable), .ldo11VoltageSelect(v11),
		.ldo12VoltageSelect(v12), .outputDischargeEnable(dis),
		.globalOff(globalOff), .powerCycleStart(pcStart),
		.softResetStart(srStart), .irqN(irqN)
	);

	plsc_board_model u_board (
		.clk(clk), .reset(reset), .ldoOn(ldoEnable[1:0]),
		.faultReq(evt[5:4]), .powerGood(powerGood),
		.ldoFault(ldoFault)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 8) begin
			@(posedge clk);
			k++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k == 8)
			chk("pready", 32'h0, 32'h1);
	endtask

	task automatic w(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'b00, idx, 2'b00}, d);
	endtask

	task automatic r(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
		chk($sformatf("reg %h", idx), rd, {24'h000000, e});
	endtask

	task automatic pulse(input logic [5:0] m);
		@(posedge clk);
		evt <= m;
		@(posedge clk);
		evt <= 6'h00;
	endtask

	task automatic waitStart(input logic s, output int k);
		k = 0;
		while ((s ? srStart : pcStart) !== 1'b1 && k < 60) begin
			@(posedge clk);
			k++;
		end
	endtask

	// ------------------------------------------------------------
	// Timeout
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		r(IDX_INT_ADDR, 8'hff);
		r(IDX_BTN_CTRL, 8'h00);
		chk("irqN", irqN, 1'b1);
		w(IDX_LDO11_VSEL, 8'hff);
		r(IDX_LDO11_VSEL, 8'h3f);
		chk("v11", v11, 6'h3f);
		w(IDX_LDO12_VSEL, 8'h15);
		// Register lands at the access edge; look one edge later
		@(posedge clk);
		chk("v12", v12, 6'h15);
		w(IDX_LDO11_CTRL, 8'hfe);
		repeat (3) @(posedge clk);
		chk("en", ldoEnable, 3'b001);
		chk("dis", dis, 2'b00);
		r(IDX_LDO11_CTRL, 8'h87);
		w(IDX_LDO11_CTRL, 8'h04);
		repeat (3) @(posedge clk);
		chk("en", ldoEnable, 3'b000);
		chk("dis", dis, 2'b01);
		r(IDX_LDO11_CTRL, 8'h04);
		w(IDX_KEEP_CTRL, 8'hff);
		r(IDX_KEEP_CTRL, 8'h80);
		chk("keep", ldoEnable[2], 1'b1);
		// Regulator fault, enabled then suppressed
		w(IDX_LDO12_CTRL, 8'h82);
		repeat (3) @(posedge clk);
		pulse(6'h20);
		repeat (4) @(posedge clk);
		chk("irqN", irqN, 1'b0);
		r(IDX_INT_ADDR, 8'ha0);
		r(IDX_INT_ADDR, 8'hff);
		r(IDX_LDO12_CTRL, 8'h83);
		repeat (2) @(posedge clk);
		chk("irqN", irqN, 1'b1);
		w(IDX_LDO12_CTRL, 8'h80);
		pulse(6'h20);
		repeat (4) @(posedge clk);
		chk("irqN", irqN, 1'b1);
		r(IDX_INT_ADDR, 8'hff);
		// Push-button press and release
		w(IDX_BTN_CTRL, 8'hc0);
		w(IDX_BTN_STAT, 8'hff);
		r(IDX_BTN_STAT, 8'h00);
		@(posedge clk);
		pushButtonInN <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irqN", irqN, 1'b0);
		r(IDX_INT_ADDR, 8'hc0);
		r(IDX_BTN_STAT, 8'ha0);
		repeat (2) @(posedge clk);
		chk("irqN", irqN, 1'b1);
		@(posedge clk);
		pushButtonInN <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irqN", irqN, 1'b0);
		r(IDX_BTN_STAT, 8'h40);
		r(IDX_INT_ADDR, 8'hc0);
		// Watchdog: power cycle outranks soft reset
		w(IDX_BTN_CTRL, 8'h03);
		pulse(6'h01);
		waitStart(1'b0, n);
		chk("pcStart", n < 60, 1'b1);
		chk("srStart", srStart, 1'b0);
		w(IDX_BTN_CTRL, 8'h02);
		pulse(6'h01);
		waitStart(1'b1, n);
		chk("srStart", n < 60, 1'b1);
		w(IDX_BTN_CTRL, 8'h03);
		pulse(6'h02);
		r(IDX_BTN_CTRL, 8'h00);
		// Flags set by power cycle and soft reset, cleared on read
		pulse(6'h0c);
		r(IDX_RST_FLAGS, 8'h03);
		r(IDX_RST_FLAGS, 8'h00);
		// Clock enable low: flag events must not land
		@(posedge clk);
		ce <= 1'b0;
		pulse(6'h0c);
		ce <= 1'b1;
		r(IDX_RST_FLAGS, 8'h00);
		// Software power cycle after the shortened delay
		w(IDX_SYS_CTRL, 8'h01);
		waitStart(1'b0, n);
		chk("delay", n >= SD - 3 && n <= SD + 3, 1'b1);
		r(IDX_SYS_CTRL, 8'h00);
		// Global off needs arming in an earlier write
		w(IDX_LDO11_CTRL, 8'h80);
		w(IDX_SYS_CTRL, 8'h18);
		repeat (3) @(posedge clk);
		chk("off", globalOff, 1'b0);
		w(IDX_SYS_CTRL, 8'h08);
		w(IDX_SYS_CTRL, 8'h18);
		repeat (3) @(posedge clk);
		chk("off", globalOff, 1'b1);
		chk("en", ldoEnable, 3'b000);
		r(IDX_SYS_CTRL, 8'h18);
		w(IDX_SYS_CTRL, 8'h00);
		repeat (3) @(posedge clk);
		chk("en", ldoEnable, 3'b111);
		// Unmapped and misaligned places
		apb(1'b0, 12'h3fc, 8'h00);
		chk("err", err, 1'b1);
		chk("rd", rd, 32'h0);
		apb(1'b0, 12'h242, 8'h00);
		chk("err", err, 1'b1);
		chk("rd", rd, 32'h0);
		apb(1'b1, 12'h241, 8'h15);
		chk("err", err, 1'b1);
		r(IDX_LDO11_VSEL, 8'h3f);
		report_and_stop();
	end
endmodule
